// file: hdl/edtsf_top.v
// Function
// - Single-buffer frame: set transmit complete when the frame fully completes.
// - Multi-buffer frame: set complete after last data when next descriptor inactive; the code sets it at the last buffer's write-back whatever the next descriptor.
// - After a frame, write transmission status back into its descriptor.
// - Complete flag reads 0 until transfer completes, then 1.
// - Inactive descriptor fetched mid-frame sets descriptor-empty flag.
// - Restart after reset begins at the descriptor list base address.
// - FIFO running dry during a frame sets the underflow flag.
// - All status sources combine onto one controller interrupt line.
`timescale 1ns/10ps
`default_nettype none
`include "edtsf_consts.vh"
module edtsf_top (
   input wire clk_in,
   input wire rst_n_in,

   // Register port
   input wire [`EDTSF_ADDR_W-1:0] addr_in,
   input wire [31:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [31:0] rdata_out,

   // Descriptor fetch
   output wire desc_fetch_req_out,
   output reg [31:0] desc_addr_out,
   input wire desc_valid_in,
   input wire tx_descriptor_active_bit_in,
   input wire desc_last_in,

   // Transmitter side
   input wire frame_done_in,
   input wire fifo_empty_in,
   input wire mac_busy_in,
   input wire mac_tx_status_in,

   // Status write-back and interrupt
   output reg wb_valid_out,
   output reg [31:0] wb_addr_out,
   output reg [31:0] wb_status_out,
   output wire controller_irq_line_out
);
   localparam ST_IDLE = 4'b0001;
   localparam ST_FETCH = 4'b0010;
   localparam ST_SEND = 4'b0100;
   localparam ST_WB = 4'b1000;

   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg tc_reg;
   reg tx_descriptor_empty_flag_reg;
   reg tx_fifo_underflow_flag_reg;
   reg [31:0] mask_reg;
   reg [31:0] tx_descriptor_list_base_reg;
   reg in_frame_reg;
   reg last_reg;
   reg set_tc;
   reg set_tde;
   reg set_uf;

   function wr_hit;
      input [`EDTSF_ADDR_W-1:0] off;
      begin
         wr_hit = wr_in && (addr_in == off);
      end
   endfunction

   // Set wins over a same-cycle write-1-to-clear so no event is lost
   function flag_next;
      input cur;
      input set;
      input clr;
      begin
         if (set)
            flag_next = 1'b1;
         else if (clr)
            flag_next = 1'b0;
         else
            flag_next = cur;
      end
   endfunction

   wire wr_status = wr_hit(`EDTSF_OFF_STATUS);
   wire wr_mask = wr_hit(`EDTSF_OFF_MASK);
   wire wr_base = wr_hit(`EDTSF_OFF_BASE);
   wire wr_ctrl = wr_hit(`EDTSF_OFF_CTRL);
   // Soft reset restarts the engine only; flags, mask and base survive it
   wire swrst = wr_ctrl && wdata_in[`EDTSF_CTRL_SWRST];
   wire start = wr_ctrl && wdata_in[`EDTSF_CTRL_START];
   wire [31:0] status = {10'h000, tc_reg, tx_descriptor_empty_flag_reg,
      tx_fifo_underflow_flag_reg, 19'h00000};

   wire [2:0] flag_clr;
   wire tc_next = flag_next(tc_reg, set_tc, flag_clr[2]);
   wire tde_next = flag_next(tx_descriptor_empty_flag_reg, set_tde, flag_clr[1]);
   wire uf_next = flag_next(tx_fifo_underflow_flag_reg, set_uf, flag_clr[0]);

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_clr
         // Clear bits sit at the flag positions, lowest flag first
         assign flag_clr[g] = wr_status && wdata_in[`EDTSF_BIT_TX_FIFO_UNDERFLOW_FLAG + g];
      end
   endgenerate

   assign desc_fetch_req_out = (state_reg == ST_FETCH);
   assign controller_irq_line_out = |(status & mask_reg);

   always @* begin
      state_next = state_reg;
      set_tc = 1'b0;
      set_tde = 1'b0;
      set_uf = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            // Only a start write moves the engine off idle
            if (start)
               state_next = ST_FETCH;
         end
         ST_FETCH: begin
            // Request stays up until the descriptor comes back
            if (desc_valid_in) begin
               if (tx_descriptor_active_bit_in)
                  state_next = ST_SEND;
               else begin
                  // Mid-frame empty leaves a truncated frame; idle until the next start write
                  set_tde = in_frame_reg;
                  set_tc = !in_frame_reg;
                  state_next = ST_IDLE;
               end
            end
         end
         ST_SEND: begin
            // Transmitter wants data the FIFO does not have
            if (fifo_empty_in && mac_busy_in)
               set_uf = 1'b1;
            if (frame_done_in)
               state_next = ST_WB;
         end
         ST_WB: begin
            // One cycle of write-back, then the next descriptor
            set_tc = last_reg;
            state_next = ST_FETCH;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always @(posedge clk_in) begin
      if (!rst_n_in || swrst) begin
         state_reg <= ST_IDLE;
         in_frame_reg <= 1'b0;
         last_reg <= 1'b0;
         desc_addr_out <= `EDTSF_BASE_RST;
         wb_valid_out <= 1'b0;
         wb_addr_out <= 32'h00000000;
         wb_status_out <= 32'h00000000;
      end else begin
         state_reg <= state_next;
         wb_valid_out <= 1'b0;
         if (state_reg == ST_IDLE && start)
            desc_addr_out <= tx_descriptor_list_base_reg;
         if (state_reg == ST_FETCH && desc_valid_in && tx_descriptor_active_bit_in)
            last_reg <= desc_last_in;
         // Status lands at the address the descriptor was read from
         if (state_reg == ST_WB) begin
            wb_valid_out <= 1'b1;
            wb_addr_out <= desc_addr_out;
            wb_status_out <= {31'h00000000, mac_tx_status_in};
            in_frame_reg <= !last_reg;
            desc_addr_out <= desc_addr_out + `EDTSF_DESC_BYTES;
         end
      end
   end

   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         tc_reg <= 1'b0;
         tx_descriptor_empty_flag_reg <= 1'b0;
         tx_fifo_underflow_flag_reg <= 1'b0;
      end else begin
         tc_reg <= tc_next;
         tx_descriptor_empty_flag_reg <= tde_next;
         tx_fifo_underflow_flag_reg <= uf_next;
      end
   end

   // Configuration registers are plain read/write words
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         mask_reg <= `EDTSF_MASK_RST;
         tx_descriptor_list_base_reg <= `EDTSF_BASE_RST;
      end else begin
         if (wr_mask)
            mask_reg <= wdata_in;
         if (wr_base)
            tx_descriptor_list_base_reg <= wdata_in;
      end
   end

   // Read data stands for one cycle only and is zero otherwise
   always @(posedge clk_in) begin
      if (!rst_n_in)
         rdata_out <= 32'h00000000;
      else if (rd_in) begin
         case (addr_in)
            `EDTSF_OFF_STATUS: rdata_out <= status;
            `EDTSF_OFF_MASK: rdata_out <= mask_reg;
            `EDTSF_OFF_BASE: rdata_out <= tx_descriptor_list_base_reg;
            `EDTSF_OFF_CTRL: rdata_out <= {28'h0000000, state_reg};
            default: rdata_out <= 32'h00000000;
         endcase
      end else
         rdata_out <= 32'h00000000;
   end
endmodule
`default_nettype wire

// file: hdl/edtsf_consts.vh
`ifndef EDTSF_CONSTS_VH
`define EDTSF_CONSTS_VH
`define EDTSF_ADDR_W 4
`define EDTSF_OFF_STATUS 4'h0
`define EDTSF_OFF_MASK 4'h4
`define EDTSF_OFF_BASE 4'h8
`define EDTSF_OFF_CTRL 4'hc
`define EDTSF_BIT_TC 21
`define EDTSF_BIT_TDE 20
`define EDTSF_BIT_TX_FIFO_UNDERFLOW_FLAG 19
`define EDTSF_CTRL_SWRST 0
`define EDTSF_CTRL_START 1
`define EDTSF_MASK_RST 32'h00000000
`define EDTSF_BASE_RST 32'h00000000
`define EDTSF_DESC_BYTES 32'h00000010
`endif

// file: testbench/edtsf_checker.sv
`timescale 1ns/10ps
`default_nettype none
module edtsf_chk (
   input wire logic clk_in, rst_n_in, rd_in, wr_in, frame_done_in, desc_valid_in,
   input wire logic desc_fetch_req_out, wb_valid_out, controller_irq_line_out,
   input wire logic tx_descriptor_active_bit_in,
   input wire logic [3:0] addr_in,
   input wire logic [31:0] wdata_in, rdata_out, desc_addr_out, wb_addr_out);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   AST_RDZ: assert property (!$past(rd_in) |-> !rdata_out) else $error("stray rdata");
   AST_WBP: assert property (wb_valid_out |=> !wb_valid_out) else $error("long wb");
   AST_WBD: assert property (wb_valid_out |-> $past(frame_done_in) | $past(frame_done_in, 2))
      else $error("wb without frame end");
   AST_WBA: assert property (wb_valid_out |-> ##[0:1] desc_addr_out == wb_addr_out + 32'h10)
      else $error("wb address");
   AST_WBF: assert property (wb_valid_out |-> ##[0:1] desc_fetch_req_out)
      else $error("no fetch after wb");
   AST_REQ: assert property (desc_fetch_req_out & !desc_valid_in & !wr_in |=> desc_fetch_req_out)
      else $error("fetch dropped");
   AST_ADR: assert property (desc_fetch_req_out & $past(desc_fetch_req_out) |-> $stable(desc_addr_out))
      else $error("fetch address moved");
   AST_MSK: assert property (wr_in & addr_in == 4'h4 & !wdata_in |=> !controller_irq_line_out)
      else $error("masked irq");
   AST_RST: assert property ($rose(rst_n_in) |-> !(controller_irq_line_out | wb_valid_out))
      else $error("reset state");
   cover property (wb_valid_out);
   cover property (desc_valid_in & !tx_descriptor_active_bit_in);
   cover property (controller_irq_line_out);
endmodule
bind edtsf_top edtsf_chk chk_u (.*);
`default_nettype wire

// file: testbench/edtsf_far.sv
`timescale 1ns/10ps
`default_nettype none
module edtsf_far (
   input wire logic clk_in, desc_fetch_req_out,
   input wire logic [31:0] desc_addr_out,
   input wire logic [15:0] act, lst,
   output logic desc_valid_in, tx_descriptor_active_bit_in, desc_last_in,
   output logic mac_busy_in, frame_done_in);
   logic [3:0] n = 4'h0;
   wire logic go = desc_fetch_req_out & !desc_valid_in & n[0];
   initial {desc_valid_in, mac_busy_in, frame_done_in} = 3'h0;
   always @(posedge clk_in) begin
      n <= n + 4'h1;
      desc_valid_in <= go;
      // Fields toggle outside the valid pulse so a late sample shows up
      tx_descriptor_active_bit_in <= go ? act[desc_addr_out[7:4]] : !tx_descriptor_active_bit_in;
      desc_last_in <= go ? lst[desc_addr_out[7:4]] : !desc_last_in;
      frame_done_in <= mac_busy_in & n == 4'hf;
      mac_busy_in <= desc_valid_in & tx_descriptor_active_bit_in | mac_busy_in & !frame_done_in;
   end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, fifo_empty_in = 1'b0;
   logic [3:0] addr_in = 4'h0;
   logic [15:0] act = 16'h0, lst = 16'h0;
   logic [31:0] wdata_in = 32'h0, rv;
   wire logic [31:0] rdata_out, desc_addr_out, wb_addr_out, wb_status_out;
   wire logic desc_fetch_req_out, wb_valid_out, controller_irq_line_out, desc_valid_in;
   wire logic tx_descriptor_active_bit_in, desc_last_in, frame_done_in, mac_busy_in;
   wire logic mac_tx_status_in = 1'b1;
   logic [67:0] rows [3] = '{{4'h8, 32'h100, 32'h100}, {4'h4, 32'h380000, 32'h380000},
      {4'h2, 32'hffffffff, 32'h0}};
   integer n_errors = 0, checked = 0, nwb = 0, i;
   logic [31:0] wba = 32'h0, wbs = 32'h0;
   edtsf_top dut_u (.*);
   edtsf_far far_u (.*);
   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) if (wb_valid_out === 1'b1) begin
      nwb <= nwb + 1;
      wba <= wb_addr_out;
      wbs <= wb_status_out;
   end
   task chk(input [31:0] g, e); begin
      checked++;
      if (g !== e) begin $display("CHECK FAILED %0t %h %h", $time, g, e); n_errors++; end
   end endtask
   task wr(input [3:0] a, input [31:0] d); begin
      @(posedge clk_in) {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
      @(posedge clk_in) wr_in <= 1'b0;
   end endtask
   task rd(input [3:0] a); begin
      @(posedge clk_in) {rd_in, addr_in} <= {1'b1, a};
      @(posedge clk_in) rd_in <= 1'b0;
      @(posedge clk_in) rv = rdata_out;
   end endtask
   // Soft reset, start, then poll the state until idle
   task run(input [15:0] a, l); begin
      act <= a;
      lst <= l;
      rv = 32'h0;
      wr(4'hc, 32'h1);
      wr(4'hc, 32'h2);
      @(negedge clk_in) chk(desc_addr_out, 32'h100);
      for (i = 0; i < 99 && rv !== 32'h1; i++) rd(4'hc);
      chk(rv, 32'h1);
   end endtask
   task results; begin
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   end endtask
   initial begin #100000 n_errors++; results; end
   initial begin
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(4'h0); chk(rv, 32'h0);
      foreach (rows[j]) begin
         wr(rows[j][67:64], rows[j][63:32]);
         rd(rows[j][67:64]); chk(rv, rows[j][31:0]);
      end
      run(16'h3, 16'h3);
      rd(4'h0); chk(rv, 32'h200000);
      chk(nwb, 32'h2);
      chk(wba, 32'h110);
      chk(wbs, 32'h1);
      chk(controller_irq_line_out, 32'h1);
      wr(4'h0, 32'h200000); rd(4'h0); chk(rv, 32'h0);
      fifo_empty_in <= 1'b1;
      run(16'h1, 16'h0);
      rd(4'h0); chk(rv, 32'h180000);
      fifo_empty_in <= 1'b0;
      run(16'h3, 16'h2);
      rd(4'h0); chk(rv, 32'h380000);
      wr(4'h4, 32'h0);
      results;
   end
endmodule
`default_nettype wire
